//--- pkg/flash_ctrl_consts.svh
// Constants of the flash command controller
//
// Overview of operation
// R1 - Commands need the valid unlock key first
// R2 - Key match permits only the next command
// R3 - Key register cleared when operation completes
// R4 - Core held on command write until done
// R5 - Interrupts deferred until operation completes
// R6 - Only instruction execution stalls, peripherals run
// R7 - Eight-bit command register, resets zero, starts operation
// R8 - Code 1 programs data byte at address
// R9 - Code 2 erases the addressed 512-byte page
// R10 - Code 3 erases whole 62 kB user flash
// R11 - Code 4 reads addressed byte into data
// R12 - Code 8 programs page protection data
// R13 - Protection byte address uses low register only
// R14 - One read-protect bit per four pages
// R15 - Reserved codes start nothing, change nothing; code still sets op_refused_o on them
// R16 - Page number is address bits 15..9
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

// ----------------------------------------
// Register addresses on the SFR bus
// ----------------------------------------
`define ADDR_FLASH_COMMAND      8'hb9
`define ADDR_FLASH_UNLOCK_KEY   8'hba
`define ADDR_FLASH_DATA_BYTE    8'hbc
`define ADDR_FLASH_ADDRESS_LOW  8'hc6
`define ADDR_FLASH_ADDRESS_HIGH 8'hc7

// ----------------------------------------
// Reset values and key
// ----------------------------------------
`define RST_COMMAND   8'h00
`define RST_KEY       8'hff
`define RST_DATA      8'h00
`define RST_ADDR      8'h00
`define UNLOCK_KEY    8'h3b

// ----------------------------------------
// Address layout
// ----------------------------------------
`define PAGE_MSB      15
`define PAGE_LSB      9
`define GROUP_SHIFT   2
`define PROT_HIGH     8'hf7
`define PROT_FIRST    16'hf7eb
`define LAST_USER     16'hf7ff

// ----------------------------------------
// Operation times in ns, at 200 MHz
// ----------------------------------------
`define CLK_MHZ       200
`define T_READ_NS     100
`define T_PROG_NS     20000
`define T_ERASE_NS    2000000
`define T_ERASE_ALL_NS 20000000
// Divide first: the longest erase time times the clock overflows an int
`define NS_TO_CYC(t)  ((t) / (1000 / `CLK_MHZ))

`endif

//--- pkg/flash_ctrl_pkg.sv
// Types of the flash command controller
package flash_ctrl_pkg;

   typedef enum logic [7:0] {
      CMD_NONE       = 8'h00,
      CMD_WRITE_BYTE = 8'h01,
      CMD_ERASE_PAGE = 8'h02,
      CMD_ERASE_ALL  = 8'h03,
      CMD_READ_BYTE  = 8'h04,
      CMD_PROTECT    = 8'h08
   } flash_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } ctrl_state_t;

endpackage : flash_ctrl_pkg

//--- design/flash_op_timer.sv
// Down-counter that times one flash operation
`timescale 1ns/1ps
module flash_op_timer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] count_i,
   output logic                  busy_o,
   output logic                  done_o
);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   generate
      if (WIDTH < 2 || WIDTH > 31)
      begin : g_bad_width
         $error("flash_op_timer: WIDTH out of range");
      end
   endgenerate

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic             last_w;

   assign last_w = (cnt_q == WIDTH'(1));
   assign busy_o = (cnt_q != '0);
   assign done_o = last_w;

   always_comb
   begin
      cnt_d = cnt_q;
      if (load_i)
         cnt_d = count_i;
      else if (busy_o)
         cnt_d = cnt_q - WIDTH'(1);
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule : flash_op_timer

//--- design/flash_command_controller.sv
// Flash command controller behind the core's SFR bus
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_command_controller
   import flash_ctrl_pkg::*;
#(
   parameter int READ_CYCLES      = `NS_TO_CYC(`T_READ_NS),
   parameter int PROG_CYCLES      = `NS_TO_CYC(`T_PROG_NS),
   parameter int ERASE_CYCLES     = `NS_TO_CYC(`T_ERASE_NS),
   parameter int ERASE_ALL_CYCLES = `NS_TO_CYC(`T_ERASE_ALL_NS),
   parameter int PAGES            = 124,
   parameter int TIMER_W          = 24
) (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   // SFR bus of the core
   input  wire logic [7:0]         sfr_addr_i,
   input  wire logic [7:0]         sfr_wdata_i,
   input  wire logic               sfr_we_i,
   input  wire logic               sfr_re_i,
   output logic      [7:0]         sfr_rdata_o,
   // Core control
   output logic                    cpu_hold_o,
   output logic                    irq_defer_o,
   // Flash array
   output logic                    flash_start_o,
   output logic      [7:0]         flash_op_o,
   output logic      [15:0]        flash_addr_o,
   output logic      [7:0]         flash_wdata_o,
   input  wire logic [7:0]         flash_rdata_i,
   input  wire logic [PAGES-1:0]   write_enable_bits_i,
   input  wire logic [31:0]        read_enable_bits_i,
   output logic                    op_refused_o
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   localparam int TMAX = (1 << TIMER_W) - 1;

   generate
      if (READ_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
          ERASE_ALL_CYCLES < 1)
      begin : g_bad_short
         $error("flash_command_controller: cycle count below one");
      end
      if (READ_CYCLES > TMAX || PROG_CYCLES > TMAX ||
          ERASE_CYCLES > TMAX || ERASE_ALL_CYCLES > TMAX)
      begin : g_bad_long
         $error("flash_command_controller: cycle count too large");
      end
      if (PAGES < 1 || PAGES > 128)
      begin : g_bad_pages
         $error("flash_command_controller: PAGES out of range");
      end
   endgenerate

   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function automatic logic [6:0] page_of(input logic [15:0] a);
      page_of = a[`PAGE_MSB:`PAGE_LSB]; // R16
   endfunction : page_of

   function automatic logic [4:0] group_of(input logic [15:0] a);
      group_of = 5'(page_of(a) >> `GROUP_SHIFT); // R14
   endfunction : group_of

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0]  command_q;
   logic [7:0]  command_d;
   logic [7:0]  key_q;
   logic [7:0]  key_d;
   logic [7:0]  data_q;
   logic [7:0]  data_d;
   logic [7:0]  addr_lo_q;
   logic [7:0]  addr_lo_d;
   logic [7:0]  addr_hi_q;
   logic [7:0]  addr_hi_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic [7:0]  op_q;
   logic [15:0] op_addr_q;
   logic        refused_q;
   logic        refused_d;
   ctrl_state_t state_q;
   ctrl_state_t state_d;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire wr_cmd  = sfr_we_i && (sfr_addr_i == `ADDR_FLASH_COMMAND);
   wire wr_key  = sfr_we_i && (sfr_addr_i == `ADDR_FLASH_UNLOCK_KEY);
   wire wr_data = sfr_we_i && (sfr_addr_i == `ADDR_FLASH_DATA_BYTE);
   wire wr_lo   = sfr_we_i && (sfr_addr_i == `ADDR_FLASH_ADDRESS_LOW);
   wire wr_hi   = sfr_we_i && (sfr_addr_i == `ADDR_FLASH_ADDRESS_HIGH);

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   wire [15:0] user_addr = {addr_hi_q, addr_lo_q};
   // Protection bytes live in the top page; high byte ignored
   wire [15:0] prot_addr = {`PROT_HIGH, addr_lo_q}; // R13
   wire [15:0] cmd_addr  =
      (sfr_wdata_i == CMD_PROTECT) ? prot_addr : user_addr;

   wire code_valid =
      (sfr_wdata_i == CMD_WRITE_BYTE) || // R8
      (sfr_wdata_i == CMD_ERASE_PAGE) || // R9
      (sfr_wdata_i == CMD_ERASE_ALL)  || // R10
      (sfr_wdata_i == CMD_READ_BYTE)  || // R11
      (sfr_wdata_i == CMD_PROTECT);      // R12

   wire key_ok = (key_q == `UNLOCK_KEY); // R1 R2

   // Erased bit is one, so a zero marks the page protected
   wire page_wp  = (32'(page_of(user_addr)) < PAGES) ?
                   !write_enable_bits_i[page_of(user_addr)] : 1'b1;
   wire group_rp = !read_enable_bits_i[group_of(user_addr)]; // R14
   wire in_prot  = (user_addr >= `PROT_FIRST);

   // Reads of the protection area stay allowed for status checks
   wire blocked =
      ((sfr_wdata_i == CMD_WRITE_BYTE) && (page_wp || in_prot)) ||
      ((sfr_wdata_i == CMD_ERASE_PAGE) && page_wp) ||
      ((sfr_wdata_i == CMD_READ_BYTE) && group_rp && !in_prot);

   wire idle    = (state_q == ST_IDLE);
   wire accept  = wr_cmd && idle && code_valid && key_ok; // R1 R15
   wire start   = accept && !blocked;
   wire reject  = accept && blocked;

   // ----------------------------------------
   // Operation time
   // ----------------------------------------
   logic [TIMER_W-1:0] op_cycles;

   always_comb
   begin
      case (sfr_wdata_i)
         CMD_WRITE_BYTE : op_cycles = TIMER_W'(PROG_CYCLES);
         CMD_PROTECT    : op_cycles = TIMER_W'(PROG_CYCLES);
         CMD_ERASE_PAGE : op_cycles = TIMER_W'(ERASE_CYCLES);
         CMD_ERASE_ALL  : op_cycles = TIMER_W'(ERASE_ALL_CYCLES);
         CMD_READ_BYTE  : op_cycles = TIMER_W'(READ_CYCLES);
         default        : op_cycles = TIMER_W'(1);
      endcase
   end

   logic timer_done;

   flash_op_timer #(
      .WIDTH (TIMER_W)
   ) u_timer (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .load_i   (start),
      .count_i  (op_cycles),
      .busy_o   (),
      .done_o   (timer_done)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE :
            if (start)
               state_d = ST_RUN;
         ST_RUN :
            if (timer_done)
               state_d = ST_IDLE;
         default :
            state_d = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Register next values
   // ----------------------------------------
   wire finish = (state_q == ST_RUN) && timer_done;

   always_comb
   begin
      command_d = command_q;
      key_d     = key_q;
      data_d    = data_q;
      addr_lo_d = addr_lo_q;
      addr_hi_d = addr_hi_q;
      refused_d = refused_q;
      // Core is stalled while running, so no writes collide
      if (idle)
      begin
         if (wr_key)
            key_d = sfr_wdata_i;
         if (wr_data)
            data_d = sfr_wdata_i;
         if (wr_lo)
            addr_lo_d = sfr_wdata_i;
         if (wr_hi)
            addr_hi_d = sfr_wdata_i;
         if (accept)
            command_d = sfr_wdata_i; // R7
         if (wr_cmd)
            refused_d = !start;
      end
      if (reject || finish)
         key_d = `RST_KEY; // R2 R3
      if (finish && (op_q == CMD_READ_BYTE))
         data_d = flash_rdata_i; // R11
   end

   always_comb
   begin
      case (sfr_addr_i)
         `ADDR_FLASH_COMMAND      : rdata_d = command_q;
         `ADDR_FLASH_UNLOCK_KEY   : rdata_d = key_q;
         `ADDR_FLASH_DATA_BYTE    : rdata_d = data_q;
         `ADDR_FLASH_ADDRESS_LOW  : rdata_d = addr_lo_q;
         `ADDR_FLASH_ADDRESS_HIGH : rdata_d = addr_hi_q;
         default                  : rdata_d = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Flip-flops
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_q   <= ST_IDLE;
         command_q <= `RST_COMMAND;
         key_q     <= `RST_KEY;
         data_q    <= `RST_DATA;
         addr_lo_q <= `RST_ADDR;
         addr_hi_q <= `RST_ADDR;
         refused_q <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         command_q <= command_d;
         key_q     <= key_d;
         data_q    <= data_d;
         addr_lo_q <= addr_lo_d;
         addr_hi_q <= addr_hi_d;
         refused_q <= refused_d;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rdata_q <= 8'h00;
      else if (sfr_re_i)
         rdata_q <= rdata_d;
   end

   // Launch latches the operation and its address
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         op_q          <= CMD_NONE;
         op_addr_q     <= 16'h0000;
         flash_start_o <= 1'b0;
         flash_wdata_o <= `RST_DATA;
      end
      else
      begin
         flash_start_o <= start; // R8 R9 R10 R11 R12
         if (start)
         begin
            op_q          <= sfr_wdata_i;
            op_addr_q     <= cmd_addr;
            flash_wdata_o <= data_q;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sfr_rdata_o  = rdata_q;
   assign flash_op_o   = op_q;
   assign flash_addr_o = op_addr_q;
   assign op_refused_o = refused_q;

   // Only the core pauses; timers and peripherals keep their clock
   assign cpu_hold_o  = start || (state_q == ST_RUN); // R4 R6
   assign irq_defer_o = start || (state_q == ST_RUN); // R5

endmodule : flash_command_controller

//--- verif/flash_cmd_checker_assertions.sv
// Port checker of the flash command controller
`timescale 1ns/1ps
module flash_cmd_checker #(
   parameter int READ_CYCLES      = 20,
   parameter int PROG_CYCLES      = 4000,
   parameter int ERASE_CYCLES     = 400000,
   parameter int ERASE_ALL_CYCLES = 4000000
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        sfr_we_i,
   input  wire logic        cpu_hold_o,
   input  wire logic        irq_defer_o,
   input  wire logic        flash_start_o,
   input  wire logic [7:0]  flash_op_o,
   input  wire logic [15:0] flash_addr_o
);
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [7:0] key_q;
   logic       ran_q;
   int         cnt_q;
   int         need;
   // Busy from launch until the hold drops
   wire        cmd_wr = sfr_we_i && sfr_addr_i == 8'hb9 && !flash_start_o &&
                        !(ran_q && cpu_hold_o);
   assign need = (flash_op_o == 8'h04) ? READ_CYCLES :
                 (flash_op_o == 8'h02) ? ERASE_CYCLES :
                 (flash_op_o == 8'h03) ? ERASE_ALL_CYCLES : PROG_CYCLES;
   // Stale key only weakens the check, never fires it falsely
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         key_q <= 8'hff;
         ran_q <= 1'b0;
         cnt_q <= 0;
      end
      else
      begin
         cnt_q <= cpu_hold_o ? cnt_q + 1 : 0;
         ran_q <= flash_start_o | (ran_q & cpu_hold_o);
         // A key written as the hold drops must not be lost
         if (sfr_we_i && sfr_addr_i == 8'hba && !cpu_hold_o)
            key_q <= sfr_wdata_i;
         else if (ran_q && !cpu_hold_o)
            key_q <= 8'hff;
      end
   end
   start_hold_a:
      assert property (flash_start_o |-> cpu_hold_o)
         else $error("launch without core hold");
   defer_hold_a:
      assert property (irq_defer_o == cpu_hold_o)
         else $error("interrupt defer differs from hold");
   start_cause_a:
      assert property ($rose(flash_start_o) |->
         $past(sfr_we_i) && $past(sfr_addr_i) == 8'hb9)
         else $error("launch without command write");
   no_key_a:
      assert property (cmd_wr && key_q != 8'h3b |=> !flash_start_o)
         else $error("launch without valid key");
   reserved_a:
      assert property (cmd_wr && sfr_wdata_i inside {0, 5, 6, 7}
         |=> !flash_start_o) else $error("reserved code launched");
   op_code_a:
      assert property (flash_start_o |-> flash_op_o inside {1, 2, 3, 4, 8})
         else $error("launched code not defined");
   prot_addr_a:
      assert property (flash_start_o && flash_op_o == 8'h08 |->
         flash_addr_o[15:8] == 8'hf7) else $error("protect address high");
   op_stable_a:
      assert property (ran_q && cpu_hold_o && !flash_start_o |->
         $stable(flash_op_o) && $stable(flash_addr_o))
         else $error("operation changed while running");
   hold_len_a:
      assert property (ran_q && !cpu_hold_o |->
         cnt_q >= need - 1 && cnt_q <= need + 2)
         else $error("hold length wrong");
endmodule : flash_cmd_checker

//--- verif/flash_array_model.sv
// Behavioural flash array facing the controller
`timescale 1ns/1ps
module flash_array_model (
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic [7:0]  op_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   // ----------------------------------------
   // Sparse cells, erased state reads all ones
   // ----------------------------------------
   logic [7:0] mem [int];
   function automatic logic [7:0] peek(int a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction : peek
   always @(posedge clk_i)
   begin
      rdata_o <= peek(addr_i);
      if (start_i)
      begin
         case (op_i)
            8'h01: mem[addr_i] = peek(addr_i) & wdata_i;
            8'h08: mem[addr_i] = peek(addr_i) & wdata_i;
            8'h02: for (int i = 0; i < 512; i++)
               mem.delete({addr_i[15:9], 9'h000} + i);
            8'h03: mem.delete();
            default: ;
         endcase
      end
   end
endmodule : flash_array_model

//--- verif/flash_command_controller_tb_top.sv
// Self-checking bench of the flash command controller
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_command_controller_tb_top;
   // ----------------------------------------
   // Stimulus, tasks and scenarios
   // ----------------------------------------
   logic         clk_i = 1'b0;
   logic         arst_n_i = 1'b0;
   logic [7:0]   sfr_addr_i = 8'h00;
   logic [7:0]   sfr_wdata_i = 8'h00;
   logic         sfr_we_i = 1'b0;
   logic         sfr_re_i = 1'b0;
   logic [7:0]   sfr_rdata_o, flash_op_o, flash_wdata_o, flash_rdata_i;
   logic         cpu_hold_o, irq_defer_o, flash_start_o, op_refused_o;
   logic [15:0]  flash_addr_o;
   logic [123:0] write_enable_bits_i = {124{1'b1}};
   logic [31:0]  read_enable_bits_i = 32'hffffffff;
   int           fail_count = 0;
   int           tests_run = 0;
   int           starts = 0;
   logic [31:0]  seed = 32'h5d9b;
   logic [7:0]   ra [6] = '{8'hb9, 8'hba, 8'hbc, 8'hc6, 8'hc7, 8'h80};
   logic [7:0]   rv [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   // Short counts keep the run small
   flash_command_controller #(.READ_CYCLES(4), .PROG_CYCLES(6),
      .ERASE_CYCLES(8), .ERASE_ALL_CYCLES(10)) flash_command_controller_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i),
      .sfr_rdata_o(sfr_rdata_o), .cpu_hold_o(cpu_hold_o),
      .irq_defer_o(irq_defer_o), .flash_start_o(flash_start_o),
      .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
      .flash_wdata_o(flash_wdata_o), .flash_rdata_i(flash_rdata_i),
      .write_enable_bits_i(write_enable_bits_i),
      .read_enable_bits_i(read_enable_bits_i), .op_refused_o(op_refused_o));
   flash_array_model flash_array_model_i (.clk_i(clk_i),
      .start_i(flash_start_o), .op_i(flash_op_o), .addr_i(flash_addr_o),
      .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i));
   initial forever #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (flash_start_o === 1'b1) starts++;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_we_i = 1'b1;
      @(negedge clk_i);
      sfr_we_i = 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [7:0] v);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_re_i = 1'b1;
      @(negedge clk_i);
      sfr_re_i = 1'b0;
      v = sfr_rdata_o;
   endtask : rd
   task automatic cmd(logic [7:0] c, int n_start);
      int n;
      int s0;
      s0 = starts;
      n = 0;
      wr(8'hba, `UNLOCK_KEY);
      wr(8'hb9, c);
      while (cpu_hold_o !== 1'b0 && n < 200)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 200, 1);
      chk(starts - s0, n_start);
   endtask : cmd
   task automatic tally_and_finish();
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #100000;
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      logic [7:0] v, d, hi, lo;
      repeat (16) @(negedge clk_i);
      arst_n_i = 1'b1;
      foreach (ra[i])
      begin
         rd(ra[i], v);
         chk(v, rv[i]);
      end
      repeat (4)
      begin
         seed = lfsr(seed);
         hi = seed[7:0] % 8'hf7;
         lo = seed[15:8];
         d = seed[23:16];
         wr(8'hbc, d);
         wr(8'hc7, hi);
         wr(8'hc6, lo);
         cmd(8'h01, 1);
         chk(flash_addr_o, {hi, lo});
         chk(flash_array_model_i.peek({hi, lo}), d);
         wr(8'hbc, ~d);
         cmd(8'h04, 1);
         rd(8'hbc, v);
         chk(v, d);
         wr(8'hb9, 8'h04);
         @(negedge clk_i);
         chk(op_refused_o, 1);
      end
      // Codes 5, 6, 7, 0 and 9 are all reserved
      for (int c = 5; c < 10; c++)
      begin
         cmd(c == 8 ? 8'h00 : c[7:0], 0);
         rd(8'hb9, v);
         chk(v, 8'h04);
      end
      wr(8'hbc, 8'h5a);
      wr(8'hc7, hi ^ 8'h02);
      wr(8'hc6, 8'h00);
      cmd(8'h01, 1);
      wr(8'hc7, {hi[7:1], ~hi[0]});
      wr(8'hc6, ~lo);
      cmd(8'h02, 1);
      chk(flash_addr_o[15:9], hi[7:1]);
      chk(flash_array_model_i.peek({hi, lo}), 8'hff);
      chk(flash_array_model_i.peek({hi ^ 8'h02, 8'h00}), 8'h5a);
      cmd(8'h03, 1);
      chk(flash_array_model_i.peek({hi ^ 8'h02, 8'h00}), 8'hff);
      wr(8'hc7, 8'h12);
      wr(8'hc6, 8'hfe);
      wr(8'hbc, 8'h0f);
      cmd(8'h08, 1);
      chk(flash_addr_o, 16'hf7fe);
      chk(flash_array_model_i.peek(16'hf7fe), 8'h0f);
      write_enable_bits_i[5] = 1'b0;
      wr(8'hc7, 8'h0a);
      cmd(8'h01, 0);
      chk(op_refused_o, 1);
      wr(8'hc7, 8'h09);
      cmd(8'h01, 1);
      read_enable_bits_i[5] = 1'b0;
      wr(8'hc7, 8'h2f);
      wr(8'hc6, 8'hff);
      cmd(8'h04, 0);
      chk(op_refused_o, 1);
      wr(8'hc7, 8'h30);
      wr(8'hc6, 8'h00);
      cmd(8'h04, 1);
      tally_and_finish();
   end
endmodule : flash_command_controller_tb_top
bind flash_command_controller flash_cmd_checker #(
   .READ_CYCLES(READ_CYCLES), .PROG_CYCLES(PROG_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES), .ERASE_ALL_CYCLES(ERASE_ALL_CYCLES))
   flash_cmd_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i),
   .cpu_hold_o(cpu_hold_o), .irq_defer_o(irq_defer_o),
   .flash_start_o(flash_start_o), .flash_op_o(flash_op_o),
   .flash_addr_o(flash_addr_o));
